// File: common/evt_ctrl_pkg.sv
package evt_ctrl_pkg;

    // ----------------
    // Sizes
    // ----------------
    localparam int NUM_CORE_EVT = 16;
    localparam int NUM_PERIPH = 64;
    localparam int REG_W = 32;
    localparam int GP_FIRST = 7;
    localparam int NUM_GP = 7;
    localparam int EVT_IDX_W = 4;

    // ----------------
    // Register byte offsets
    // ----------------
    localparam logic [7:0] OFS_CORE_LATCH = 8'h00;
    localparam logic [7:0] OFS_CORE_MASK = 8'h04;
    localparam logic [7:0] OFS_CORE_PEND = 8'h08;
    localparam logic [7:0] OFS_CTRL_STAT = 8'h0c;
    localparam logic [7:0] OFS_PMASK0 = 8'h10;
    localparam logic [7:0] OFS_PMASK1 = 8'h14;
    localparam logic [7:0] OFS_PSTAT0 = 8'h18;
    localparam logic [7:0] OFS_PSTAT1 = 8'h1c;
    localparam logic [7:0] OFS_PWAKE0 = 8'h20;
    localparam logic [7:0] OFS_PWAKE1 = 8'h24;

    // ----------------
    // Field positions in the control/status word
    // ----------------
    localparam int CTRL_GIE_BIT = 0;
    localparam int CTRL_WAKE_BIT = 1;
    localparam int CTRL_REQ_BIT = 2;

    // ----------------
    // Reset values
    // ----------------
    localparam logic [15:0] RST_CORE_LATCH = 16'h0000;
    localparam logic [15:0] RST_CORE_MASK = 16'h0000;
    localparam logic [15:0] RST_CORE_PEND = 16'h0000;
    localparam logic [31:0] RST_PMASK = 32'h0000_0000;
    localparam logic [31:0] RST_PWAKE = 32'h0000_0000;
    localparam logic RST_GIE = 1'b0;

    // ----------------
    // Bus answers
    // ----------------
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    localparam logic [1:0] RESP_DECERR = 2'b11;

endpackage

// File: logic/two_level_event_controller.sv
`timescale 1ns/1ps
// Overview of operation
// - Three 16-bit core registers: latch, mask, pending
// - Latch sets on event, clears on acceptance
// - Software latch writes only where mask clear
// - Mask bit set allows service, clear blocks
// - Core mask accessible only in supervisor mode
// - Global enable/disable of general-purpose events
// - Pending bits track active and nested events
// - Pending hardware-updated, supervisor read only
// - Peripheral mask, status, wakeup: two 32-bit words
// - Peripheral mask bit forwards or blocks event
// - Peripheral status shows live assertion
// - Wakeup-enabled peripheral wakes idle core
// - Tolerate overlapping pulses on shared input
// - Pending bits acknowledge forwarded peripheral events
// - Rising edge sets latch after two cycles
// - Latch clears when pending bit sets
// - Next edge requeued once pending is set
// - Edge to pending at least three cycles
module two_level_event_controller
    import evt_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8,
    parameter int NUM_CORE_PINS = GP_FIRST
) (
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic ARST_N,
    // AXI4-Lite write address
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    // AXI4-Lite write data
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [REG_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    // AXI4-Lite write response
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    // AXI4-Lite read address
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    // AXI4-Lite read data
    output logic RVALID,
    input wire logic RREADY,
    output logic [REG_W-1:0] RDATA,
    output logic [1:0] RRESP,
    // Event sources (asynchronous pins)
    input wire logic [NUM_PERIPH-1:0] PERIPH_IRQ,
    input wire logic [NUM_CORE_PINS-1:0] CORE_EVT_PIN,
    // Processor pipeline
    input wire logic GIE_SET,
    input wire logic GIE_CLR,
    output logic SERVICE_REQ,
    output logic [EVT_IDX_W-1:0] SERVICE_ID,
    input wire logic SERVICE_ACK,
    input wire logic SERVICE_RETURN,
    output logic [NUM_CORE_EVT-1:0] CORE_PENDING,
    // Power management and peripheral acknowledge
    input wire logic CORE_IDLE,
    output logic WAKEUP,
    output logic [NUM_PERIPH-1:0] PERIPH_ACK
);

    // ----------------
    // Helpers
    // ----------------
    function automatic logic [EVT_IDX_W-1:0] first_set(input logic [NUM_CORE_EVT-1:0] v);
        logic [EVT_IDX_W-1:0] idx;
        idx = '0;
        for (int i = NUM_CORE_EVT - 1; i >= 0; i--) begin
            if (v[i]) begin
                idx = EVT_IDX_W'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0] strb);
        logic [31:0] res;
        res = old_v;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                res[b*8 +: 8] = new_v[b*8 +: 8];
            end
        end
        return res;
    endfunction

    // ------------------------------------------------------------
    // Pin synchronisers with agreement filter
    // ------------------------------------------------------------
    localparam int NUM_PINS = NUM_PERIPH + NUM_CORE_PINS;

    logic [NUM_PINS-1:0] pin_s1_ff;
    logic [NUM_PINS-1:0] pin_s2_ff;
    logic [NUM_PINS-1:0] pin_s3_ff;
    logic [NUM_PINS-1:0] pin_filt_ff;
    logic [NUM_PERIPH-1:0] periph_lvl;
    logic [NUM_CORE_PINS-1:0] core_pin_lvl;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pin_s1_ff <= '0;
            pin_s2_ff <= '0;
            pin_s3_ff <= '0;
            pin_filt_ff <= '0;
        end else begin
            pin_s1_ff <= {CORE_EVT_PIN, PERIPH_IRQ};
            pin_s2_ff <= pin_s1_ff;
            pin_s3_ff <= pin_s2_ff;
            for (int i = 0; i < NUM_PINS; i++) begin
                if (pin_s2_ff[i] == pin_s3_ff[i]) begin
                    pin_filt_ff[i] <= pin_s3_ff[i];
                end
            end
        end
    end

    assign periph_lvl = pin_filt_ff[NUM_PERIPH-1:0];
    assign core_pin_lvl = pin_filt_ff[NUM_PINS-1:NUM_PERIPH];

    // ----------------
    // Register state
    // ----------------
    logic [NUM_CORE_EVT-1:0] core_latch_ff;
    logic [NUM_CORE_EVT-1:0] core_mask_ff;
    logic [NUM_CORE_EVT-1:0] core_pend_ff;
    logic [NUM_PERIPH-1:0] periph_mask_ff;
    logic [NUM_PERIPH-1:0] periph_wake_ff;
    logic gie_ff;

    // ------------------------------------------------------------
    // System stage: forward unmasked peripheral events
    // ------------------------------------------------------------
    logic [NUM_PERIPH-1:0] periph_fwd;
    logic [NUM_CORE_EVT-1:0] evt_in;

    assign periph_fwd = periph_lvl & periph_mask_ff;

    // Shared inputs are a plain OR, so overlapping pulses merge
    always_comb begin
        evt_in = '0;
        evt_in[NUM_CORE_PINS-1:0] = core_pin_lvl;
        for (int i = 0; i < NUM_PERIPH; i++) begin
            evt_in[GP_FIRST + (i % NUM_GP)] = evt_in[GP_FIRST + (i % NUM_GP)]
                                              | periph_fwd[i];
        end
    end

    // ------------------------------------------------------------
    // Core stage: edge detection, two cycles
    // ------------------------------------------------------------
    logic [NUM_CORE_EVT-1:0] evt_s1_ff;
    logic [NUM_CORE_EVT-1:0] evt_s2_ff;
    logic [NUM_CORE_EVT-1:0] evt_rise;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            evt_s1_ff <= '0;
            evt_s2_ff <= '0;
        end else begin
            evt_s1_ff <= evt_in;
            evt_s2_ff <= evt_s1_ff;
        end
    end

    assign evt_rise = evt_s1_ff & ~evt_s2_ff;

    // ----------------
    // Service selection
    // ----------------
    logic [NUM_CORE_EVT-1:0] gp_sel;
    logic [NUM_CORE_EVT-1:0] cand;
    logic [EVT_IDX_W-1:0] cand_idx;
    logic [EVT_IDX_W-1:0] act_idx;
    logic accept;

    assign gp_sel = {NUM_CORE_EVT{1'b1}} << GP_FIRST;

    assign cand = core_latch_ff & core_mask_ff
                  & ~(gp_sel & {NUM_CORE_EVT{~gie_ff}});
    assign cand_idx = first_set(cand);
    assign act_idx = first_set(core_pend_ff);
    // Only a higher-priority event may nest over the active one
    assign SERVICE_REQ = (|cand) && (!(|core_pend_ff) || cand_idx < act_idx);
    assign SERVICE_ID = cand_idx;
    assign accept = SERVICE_REQ && SERVICE_ACK;

    // ----------------
    // AXI4-Lite slave
    // ----------------
    logic aw_held_ff;
    logic w_held_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic aw_priv_ff;
    logic [REG_W-1:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic rvalid_ff;
    logic [1:0] rresp_ff;
    logic [REG_W-1:0] rdata_ff;
    logic do_write;
    logic [7:0] wr_ofs;
    logic [7:0] rd_ofs;
    logic wr_priv_ok;
    logic [1:0] wr_resp;
    logic [REG_W-1:0] rd_val;
    logic [1:0] rd_resp;

    assign AWREADY = !aw_held_ff;
    assign WREADY = !w_held_ff;
    assign ARREADY = !rvalid_ff;
    assign BVALID = bvalid_ff;
    assign BRESP = bresp_ff;
    assign RVALID = rvalid_ff;
    assign RRESP = rresp_ff;
    assign RDATA = rdata_ff;

    assign do_write = aw_held_ff && w_held_ff && !bvalid_ff;
    assign wr_ofs = 8'(aw_addr_ff);
    assign rd_ofs = 8'(ARADDR);
    assign wr_priv_ok = aw_priv_ff;

    always_comb begin
        unique case (wr_ofs)
            OFS_CORE_LATCH, OFS_PMASK0, OFS_PMASK1,
            OFS_PWAKE0, OFS_PWAKE1, OFS_CTRL_STAT, OFS_PSTAT0, OFS_PSTAT1: begin
                wr_resp = RESP_OKAY;
            end
            OFS_CORE_MASK, OFS_CORE_PEND: begin
                wr_resp = wr_priv_ok ? RESP_OKAY : RESP_SLVERR;
            end
            default: begin
                wr_resp = RESP_DECERR;
            end
        endcase
    end

    always_comb begin
        rd_val = '0;
        rd_resp = RESP_OKAY;
        unique case (rd_ofs)
            OFS_CORE_LATCH: rd_val[NUM_CORE_EVT-1:0] = core_latch_ff;
            OFS_CORE_MASK: begin
                if (ARPROT[0]) begin
                    rd_val[NUM_CORE_EVT-1:0] = core_mask_ff;
                end else begin
                    rd_resp = RESP_SLVERR;
                end
            end
            OFS_CORE_PEND: begin
                if (ARPROT[0]) begin
                    rd_val[NUM_CORE_EVT-1:0] = core_pend_ff;
                end else begin
                    rd_resp = RESP_SLVERR;
                end
            end
            OFS_CTRL_STAT: begin
                rd_val[CTRL_GIE_BIT] = gie_ff;
                rd_val[CTRL_WAKE_BIT] = WAKEUP;
                rd_val[CTRL_REQ_BIT] = SERVICE_REQ;
            end
            OFS_PMASK0: rd_val = periph_mask_ff[31:0];
            OFS_PMASK1: rd_val = periph_mask_ff[63:32];
            OFS_PSTAT0: rd_val = periph_lvl[31:0];
            OFS_PSTAT1: rd_val = periph_lvl[63:32];
            OFS_PWAKE0: rd_val = periph_wake_ff[31:0];
            OFS_PWAKE1: rd_val = periph_wake_ff[63:32];
            default: rd_resp = RESP_DECERR;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= '0;
            aw_priv_ff <= 1'b0;
        end else if (AWVALID && !aw_held_ff) begin
            aw_held_ff <= 1'b1;
            aw_addr_ff <= AWADDR;
            aw_priv_ff <= AWPROT[0];
        end else if (do_write) begin
            aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            w_held_ff <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (WVALID && !w_held_ff) begin
            w_held_ff <= 1'b1;
            w_data_ff <= WDATA;
            w_strb_ff <= WSTRB;
        end else if (do_write) begin
            w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_resp;
        end else if (BREADY) begin
            bvalid_ff <= 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            rvalid_ff <= 1'b0;
            rresp_ff <= RESP_OKAY;
            rdata_ff <= '0;
        end else if (ARVALID && !rvalid_ff) begin
            rvalid_ff <= 1'b1;
            rresp_ff <= rd_resp;
            rdata_ff <= rd_val;
        end else if (RREADY) begin
            rvalid_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Software-written registers
    // ------------------------------------------------------------
    logic [31:0] wr_merged;

    always_comb begin
        unique case (wr_ofs)
            OFS_CORE_LATCH: wr_merged = strb_merge(32'(core_latch_ff), w_data_ff, w_strb_ff);
            OFS_CORE_MASK: wr_merged = strb_merge(32'(core_mask_ff), w_data_ff, w_strb_ff);
            OFS_PMASK0: wr_merged = strb_merge(periph_mask_ff[31:0], w_data_ff, w_strb_ff);
            OFS_PMASK1: wr_merged = strb_merge(periph_mask_ff[63:32], w_data_ff, w_strb_ff);
            OFS_PWAKE0: wr_merged = strb_merge(periph_wake_ff[31:0], w_data_ff, w_strb_ff);
            OFS_PWAKE1: wr_merged = strb_merge(periph_wake_ff[63:32], w_data_ff, w_strb_ff);
            default: wr_merged = '0;
        endcase
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            core_mask_ff <= RST_CORE_MASK;
        end else if (do_write && wr_ofs == OFS_CORE_MASK && wr_priv_ok) begin
            core_mask_ff <= wr_merged[NUM_CORE_EVT-1:0];
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            periph_mask_ff <= {RST_PMASK, RST_PMASK};
        end else if (do_write && wr_ofs == OFS_PMASK0) begin
            periph_mask_ff[31:0] <= wr_merged;
        end else if (do_write && wr_ofs == OFS_PMASK1) begin
            periph_mask_ff[63:32] <= wr_merged;
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            periph_wake_ff <= {RST_PWAKE, RST_PWAKE};
        end else if (do_write && wr_ofs == OFS_PWAKE0) begin
            periph_wake_ff[31:0] <= wr_merged;
        end else if (do_write && wr_ofs == OFS_PWAKE1) begin
            periph_wake_ff[63:32] <= wr_merged;
        end
    end

    // ------------------------------------------------------------
    // Global enable, set by one instruction and cleared by the other
    // ------------------------------------------------------------
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            gie_ff <= RST_GIE;
        end else if (GIE_SET) begin
            gie_ff <= 1'b1;
        end else if (GIE_CLR) begin
            gie_ff <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Core latch: software write, acceptance clear, edge set
    // ------------------------------------------------------------
    logic [NUM_CORE_EVT-1:0] nxt_core_latch;
    logic [NUM_CORE_EVT-1:0] accept_vec;

    assign accept_vec = accept ? (NUM_CORE_EVT'(1) << SERVICE_ID) : '0;

    always_comb begin
        nxt_core_latch = core_latch_ff;
        if (do_write && wr_ofs == OFS_CORE_LATCH) begin
            nxt_core_latch = (core_latch_ff & core_mask_ff)
                             | (wr_merged[NUM_CORE_EVT-1:0] & ~core_mask_ff);
        end
        nxt_core_latch = nxt_core_latch & ~accept_vec;
        // A new edge beats a clear in the same cycle
        nxt_core_latch = nxt_core_latch | evt_rise;
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            core_latch_ff <= RST_CORE_LATCH;
        end else begin
            core_latch_ff <= nxt_core_latch;
        end
    end

    // ------------------------------------------------------------
    // Core pending: nesting stack as a bit set
    // ------------------------------------------------------------
    logic [NUM_CORE_EVT-1:0] nxt_core_pend;

    always_comb begin
        nxt_core_pend = core_pend_ff;
        if (SERVICE_RETURN && (|core_pend_ff)) begin
            nxt_core_pend[act_idx] = 1'b0;
        end
        nxt_core_pend = nxt_core_pend | accept_vec;
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            core_pend_ff <= RST_CORE_PEND;
        end else begin
            core_pend_ff <= nxt_core_pend;
        end
    end

    assign CORE_PENDING = core_pend_ff;

    // ------------------------------------------------------------
    // Acknowledge back to the peripherals, wakeup to the idle core
    // ------------------------------------------------------------
    logic [NUM_CORE_EVT-1:0] pend_prev_ff;
    logic [NUM_CORE_EVT-1:0] pend_rise;
    logic [NUM_PERIPH-1:0] periph_ack_ff;
    logic wake_ff;

    assign pend_rise = core_pend_ff & ~pend_prev_ff;

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            pend_prev_ff <= '0;
            periph_ack_ff <= '0;
        end else begin
            pend_prev_ff <= core_pend_ff;
            for (int i = 0; i < NUM_PERIPH; i++) begin
                periph_ack_ff[i] <= pend_rise[GP_FIRST + (i % NUM_GP)]
                                    & periph_fwd[i];
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            wake_ff <= 1'b0;
        end else begin
            wake_ff <= CORE_IDLE && (|(periph_lvl & periph_wake_ff));
        end
    end

    assign PERIPH_ACK = periph_ack_ff;
    assign WAKEUP = wake_ff;

endmodule

// File: tb/two_level_event_controller_asserts.sv
`timescale 1ns/1ps
module evt_ctrl_checker
    import evt_ctrl_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // Clock, reset, read bus
    input wire logic REF_CLK,
    input wire logic ARST_N,
    input wire logic ARVALID,
    input wire logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    input wire logic RVALID,
    input wire logic [1:0] RRESP,
    // Pipeline side
    input wire logic GIE_SET,
    input wire logic GIE_CLR,
    input wire logic SERVICE_REQ,
    input wire logic [EVT_IDX_W-1:0] SERVICE_ID,
    input wire logic SERVICE_ACK,
    input wire logic SERVICE_RETURN,
    input wire logic [NUM_CORE_EVT-1:0] CORE_PENDING,
    input wire logic CORE_IDLE,
    input wire logic WAKEUP,
    input wire logic [NUM_PERIPH-1:0] PERIPH_ACK
);
    logic gie_ff;
    always_ff @(posedge REF_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            gie_ff <= 1'b0;
        end else if (GIE_SET || GIE_CLR) begin
            gie_ff <= GIE_SET;
        end
    end
    default clocking cb @(posedge REF_CLK);
    endclocking
    default disable iff (!ARST_N);
    chk_take_sets: assert property (
        SERVICE_REQ && SERVICE_ACK |=> CORE_PENDING != 16'h0000) else $error("no pending");
    chk_pend_hold: assert property (
        !SERVICE_ACK && !SERVICE_RETURN |=> $stable(CORE_PENDING)) else $error("pend moved");
    chk_ret_lowest: assert property (SERVICE_RETURN && !SERVICE_ACK |=>
        CORE_PENDING == ($past(CORE_PENDING) & ($past(CORE_PENDING) - 16'h0001)))
        else $error("bad return");
    chk_req_nest: assert property (SERVICE_REQ |->
        (CORE_PENDING & ((16'h0002 << SERVICE_ID) - 16'h0001)) == 16'h0000)
        else $error("req under active");
    chk_req_gie: assert property (
        SERVICE_REQ && SERVICE_ID >= 4'(GP_FIRST) |-> gie_ff) else $error("req while off");
    chk_wake_idle: assert property (
        WAKEUP |-> $past(CORE_IDLE)) else $error("wake not idle");
    chk_ack_rise: assert property (PERIPH_ACK != 64'h0 |->
        ($past(CORE_PENDING) & ~$past(CORE_PENDING, 2)) != 16'h0000) else $error("stray ack");
    chk_prot_read: assert property (ARVALID && ARREADY && !ARPROT[0] &&
        (ARADDR == OFS_CORE_MASK || ARADDR == OFS_CORE_PEND) |=>
        RVALID && RRESP == RESP_SLVERR) else $error("user read ok");
    cover property (SERVICE_REQ && SERVICE_ACK);
    cover property (SERVICE_RETURN && CORE_PENDING[2]);
    cover property (WAKEUP);
endmodule
bind two_level_event_controller evt_ctrl_checker #(.ADDR_W(ADDR_W)) chk_u (
    .REF_CLK, .ARST_N, .ARVALID, .ARREADY, .ARADDR, .ARPROT, .RVALID, .RRESP,
    .GIE_SET, .GIE_CLR, .SERVICE_REQ, .SERVICE_ID, .SERVICE_ACK, .SERVICE_RETURN,
    .CORE_PENDING, .CORE_IDLE, .WAKEUP, .PERIPH_ACK
);

// File: tb/pipeline_model.sv
`timescale 1ns/1ps
module pipeline_model (
    // Clock, reset, controls
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ret_en,
    input wire logic [3:0] dly,
    // Controller side
    input wire logic req,
    input wire logic [15:0] pend,
    output logic ack,
    output logic ret
);
    logic ack_ff;
    logic ret_ff;
    logic [3:0] acnt_ff;
    logic [3:0] rcnt_ff;
    assign ack = ack_ff;
    assign ret = ret_ff;
    // Accept after dly+1 cycles, return after four
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_ff <= 1'b0;
            ret_ff <= 1'b0;
            acnt_ff <= 4'h0;
            rcnt_ff <= 4'h0;
        end else begin
            ack_ff <= req && !ack_ff && acnt_ff == dly;
            acnt_ff <= (req && !ack_ff && acnt_ff != dly) ? acnt_ff + 4'h1 : 4'h0;
            ret_ff <= ret_en && pend != 16'h0 && !ret_ff && rcnt_ff == 4'h3;
            rcnt_ff <= (ret_en && pend != 16'h0 && !ret_ff) ? rcnt_ff + 4'h1 : 4'h0;
        end
    end
endmodule

// File: tb/tb_two_level_event_controller.sv
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin mismatches++; \
    $display("wrong value at %0t: %0h vs %0h", $time, (g), (e)); end end
module tb_two_level_event_controller
    import evt_ctrl_pkg::*;
;
    typedef struct {logic w; logic [7:0] a; logic p; logic [31:0] d; logic [1:0] e;} row_t;
    logic ref_clk = 1'b0, arst_n = 1'b0, gie_set = 1'b0, gie_clr = 1'b0, idle = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, ret_en = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [2:0] awprot = 3'h0, arprot = 3'h0;
    logic [31:0] wdata = 32'h0, rdata, rd;
    logic [63:0] irq = 64'h0, pack;
    logic [6:0] pin = 7'h00;
    logic [3:0] dly = 4'h0, sid;
    logic [15:0] pend;
    logic [1:0] bresp, rresp, rsp;
    logic awready, wready, bvalid, arready, rvalid, req, ack, ret, wake;
    int comparisons = 0, mismatches = 0, cycles = 0, n = 0, acks = 0;
    row_t rows[] = '{
        '{1'b0, OFS_CORE_LATCH, 1'b1, 32'h0, RESP_OKAY},
        '{1'b1, OFS_CORE_MASK, 1'b1, 32'hffff, RESP_OKAY},
        '{1'b1, OFS_CORE_MASK, 1'b0, 32'h0, RESP_SLVERR},
        '{1'b0, OFS_CORE_MASK, 1'b0, 32'h0, RESP_SLVERR},
        '{1'b0, OFS_CORE_MASK, 1'b1, 32'hffff, RESP_OKAY},
        '{1'b1, OFS_CORE_PEND, 1'b1, 32'hffff, RESP_OKAY},
        '{1'b0, OFS_CORE_PEND, 1'b1, 32'h0, RESP_OKAY},
        '{1'b1, OFS_PMASK0, 1'b0, 32'hffff_fffd, RESP_OKAY},
        '{1'b0, OFS_PMASK0, 1'b1, 32'hffff_fffd, RESP_OKAY},
        '{1'b1, OFS_PWAKE0, 1'b1, 32'h1, RESP_OKAY},
        '{1'b0, OFS_PWAKE0, 1'b1, 32'h1, RESP_OKAY},
        '{1'b1, 8'h40, 1'b1, 32'h0, RESP_DECERR},
        '{1'b0, 8'h40, 1'b1, 32'h0, RESP_DECERR}};
    two_level_event_controller dut_u (
        .REF_CLK(ref_clk), .ARST_N(arst_n), .AWVALID(awvalid), .AWREADY(awready),
        .AWADDR(awaddr), .AWPROT(awprot), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
        .WSTRB(4'hf), .BVALID(bvalid), .BREADY(1'b1), .BRESP(bresp), .ARVALID(arvalid),
        .ARREADY(arready), .ARADDR(araddr), .ARPROT(arprot), .RVALID(rvalid),
        .RREADY(1'b1), .RDATA(rdata), .RRESP(rresp), .PERIPH_IRQ(irq), .CORE_EVT_PIN(pin),
        .GIE_SET(gie_set), .GIE_CLR(gie_clr), .SERVICE_REQ(req), .SERVICE_ID(sid),
        .SERVICE_ACK(ack), .SERVICE_RETURN(ret), .CORE_PENDING(pend), .CORE_IDLE(idle),
        .WAKEUP(wake), .PERIPH_ACK(pack));
    pipeline_model pipe_u (.clk(ref_clk), .rst_n(arst_n), .ret_en(ret_en), .dly(dly),
        .req(req), .pend(pend), .ack(ack), .ret(ret));
    always #5 ref_clk = ~ref_clk;
    always @(negedge ref_clk) if (pack[0] === 1'b1) acks++;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic p);
        logic ag, wg;
        @(posedge ref_clk);
        {awaddr, awprot, wdata, awvalid, wvalid} <= {a, 2'b00, p, d, 2'b11};
        do begin
            @(negedge ref_clk);
            {ag, wg} = {awready, wready};
            @(posedge ref_clk);
            if (ag) awvalid <= 1'b0;
            if (wg) wvalid <= 1'b0;
        end while (awvalid && !ag || wvalid && !wg);
        do @(negedge ref_clk); while (bvalid !== 1'b1);
        rsp = bresp;
        @(posedge ref_clk);
    endtask
    task automatic rdr(input logic [7:0] a, input logic p);
        @(posedge ref_clk);
        {araddr, arprot, arvalid} <= {a, 2'b00, p, 1'b1};
        do @(negedge ref_clk); while (arready !== 1'b1);
        @(posedge ref_clk);
        arvalid <= 1'b0;
        do @(negedge ref_clk); while (rvalid !== 1'b1);
        {rd, rsp} = {rdata, rresp};
        @(posedge ref_clk);
    endtask
    task automatic wait_pend(input logic [15:0] m, input logic [15:0] v);
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
        end while (((pend & m) !== v || (v == 16'h0 && req !== 1'b0)) && n < 300);
        `CHK(pend & m, v)
    endtask
    task automatic drain();
        @(posedge ref_clk);
        ret_en <= 1'b1;
        wait_pend(16'hffff, 16'h0);
        @(posedge ref_clk);
        ret_en <= 1'b0;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        foreach (rows[i]) begin
            if (rows[i].w) begin
                wr(rows[i].a, rows[i].d, rows[i].p);
            end else begin
                rdr(rows[i].a, rows[i].p);
                `CHK(rd, rows[i].d)
            end
            `CHK(rsp, rows[i].e)
        end
        wr(OFS_CORE_MASK, 32'hfff7, 1'b1);
        wr(OFS_CORE_LATCH, 32'h0009, 1'b1);
        rdr(OFS_CORE_LATCH, 1'b1);
        `CHK(rd, 32'h0008)
        @(negedge ref_clk);
        `CHK(req, 1'b0)
        wr(OFS_CORE_MASK, 32'hffff, 1'b1);
        wait_pend(16'h0008, 16'h0008);
        @(posedge ref_clk);
        pin <= 7'h24;
        wait_pend(16'h000c, 16'h000c);
        `CHK(n >= 3, 1'b1)
        rdr(OFS_CORE_LATCH, 1'b1);
        `CHK(rd, 32'h0020)
        drain();
        pin <= 7'h00;
        repeat (12) @(posedge ref_clk);
        pin <= 7'h20;
        wait_pend(16'h0020, 16'h0020);
        @(posedge ref_clk);
        pin <= 7'h00;
        repeat (12) @(posedge ref_clk);
        pin <= 7'h20;
        repeat (12) @(posedge ref_clk);
        rdr(OFS_CORE_LATCH, 1'b1);
        `CHK(rd, 32'h0020)
        drain();
        {gie_set, idle, dly} <= {2'b11, 4'h5};
        @(posedge ref_clk);
        {gie_set, irq} <= {1'b0, 64'h3};
        wait_pend(16'h0080, 16'h0080);
        `CHK(wake, 1'b1)
        `CHK(pend[8], 1'b0)
        rdr(OFS_PSTAT0, 1'b1);
        `CHK(rd, 32'h3)
        drain();
        `CHK(acks, 1)
        {idle, gie_clr, irq} <= {2'b01, 64'h4};
        @(posedge ref_clk);
        gie_clr <= 1'b0;
        wait_pend(16'hffff, 16'h0);
        repeat (20) @(negedge ref_clk);
        `CHK(wake, 1'b0)
        `CHK(pend, 16'h0)
        rdr(OFS_CORE_LATCH, 1'b1);
        `CHK(rd, 32'h0200)
        gie_set <= 1'b1;
        @(posedge ref_clk);
        gie_set <= 1'b0;
        wait_pend(16'h0200, 16'h0200);
        rdr(OFS_CTRL_STAT, 1'b1);
        `CHK(rd, 32'h1)
        drain();
        arst_n <= 1'b0;
        repeat (12) @(posedge ref_clk);
        arst_n <= 1'b1;
        rdr(OFS_CORE_MASK, 1'b1);
        `CHK(rd, 32'h0)
        conclude();
    end
endmodule
